/* bench/tb_cts_top.sv */
// Self-checking testbench for the time counter and buffer search block
`timescale 1ns/10ps
module tb_cts_top
   import cts_pkg::*;
;
   logic ref_clk;
   logic reset;
   logic [10:0] reg_addr;
   logic [15:0] reg_wdata;
   logic reg_wr;
   logic reg_rd;
   logic [15:0] reg_rdata;
   logic [31:0] ext_id;
   logic [31:0] proc_req;
   logic [31:0] tx_req;
   logic [31:0] rdy;
   logic [31:0] new_data;
   logic [95:0] mask_link;
   logic [95:0] mod_num;
   logic search_busy;
   int failures;
   int cmp_count;
   int cycles;

   cts_top cts_top_i (
      .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .buf_extended_id(ext_id), .buf_processing_request_flag(proc_req),
      .buf_transmit_request_flag(tx_req), .buf_ready_flag(rdy),
      .buf_new_data_flag(new_data), .buf_mask_link_select(mask_link),
      .buf_module_number(mod_num), .search_busy(search_busy)
   );

   // ==========================================================
   // Clock, timeout and report
   always #50 ref_clk = ~ref_clk;

   always @(posedge ref_clk)
   begin
      cycles++;
      if (cycles == 3000)
      begin
         failures++;
         end_of_test();
      end
   end

   task automatic end_of_test();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   // ==========================================================
   // Register bus master
   task automatic bus_wr(input logic [10:0] a, input logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic bus_rd(input logic [10:0] a, output logic [15:0] d);
      @(posedge ref_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1;
      d = reg_rdata;
   endtask

   // ==========================================================
   // Expected search result worked out from the buffer pattern
   function automatic logic [15:0] exp_result(input logic [15:0] w);
      int n;
      logic [5:0] idx;
      logic ok;
      n = 0;
      idx = 6'h00;
      for (int i = int'(w[5:0]); i < 32; i++)
      begin
         ok = (!w[15] || !ext_id[i]) && (!w[14] || proc_req[i]) &&
              (!w[13] || (tx_req[i] && rdy[i])) && (!w[12] || mask_link[i*3+:3] == 3'h0) &&
              (!w[11] || new_data[i]) && (mod_num[i*3+:3] == w[10:8]);
         if (ok)
         begin
            if (n == 0)
               idx = 6'(i);
            n++;
         end
      end
      return {6'h00, n > 1, n > 0, 2'h0, idx};
   endfunction

   // Index is only meaningful when a hit was reported
   task automatic check_search(input logic [15:0] w);
      logic [15:0] d;
      logic [15:0] e;
      int n;
      e = exp_result(w);
      bus_wr(OFS_BUFFER_SEARCH, {w[15:8], 2'b00, w[5:0]});
      #1;
      if (w[5:0] <= 6'h1F)
         check({15'h0000, search_busy}, 16'h0001);
      n = 0;
      while (search_busy !== 1'b0 && n < 40)
      begin
         @(posedge ref_clk);
         #1;
         n++;
      end
      bus_rd(OFS_BUFFER_SEARCH, d);
      check(e[8] ? d : (d & 16'hFF00), e);
   endtask

   // ==========================================================
   // Scenarios
   task automatic test_reset_values();
      logic [15:0] d;
      bus_rd(OFS_GLOBAL_TIME_COUNTER, d);
      check(d, RST_GLOBAL_TIME_COUNTER);
      bus_rd(OFS_BUFFER_SEARCH, d);
      check(d, RST_BUFFER_SEARCH_RESULT);
      $display("test reset values done");
   endtask

   task automatic test_counter();
      logic [15:0] d;
      bus_wr(OFS_GLOBAL_TIME_COUNTER, 16'hFFFF);
      bus_rd(OFS_GLOBAL_TIME_COUNTER, d);
      check(d, 16'h0000);
      repeat (12) @(posedge ref_clk);
      bus_rd(OFS_GLOBAL_TIME_COUNTER, d);
      check(d, 16'h0001);
      repeat (9) @(posedge ref_clk);
      bus_rd(OFS_GLOBAL_TIME_COUNTER, d);
      check(d, 16'h0002);
      @(posedge ref_clk);
      #1;
      check(reg_rdata, 16'h0000);
      bus_wr(11'h400, 16'h1234);
      bus_rd(11'h400, d);
      check(d, 16'h0000);
      $display("test counter done");
   endtask

   task automatic test_criteria();
      check_search(16'h0000);
      check_search(16'h8000);
      check_search(16'h4100);
      check_search(16'h2200);
      check_search(16'h1000);
      check_search(16'h1008);
      check_search(16'h0801);
      check_search(16'h0806);
      check_search(16'hC900);
      check_search(16'hF800);
      check_search(16'h001F);
      check_search(16'h0300);
      check_search(16'h0020);
      $display("test criteria done");
   endtask

   task automatic test_restart();
      logic [15:0] d;
      check_search(16'h0801);
      bus_wr(OFS_BUFFER_SEARCH, 16'h0000);
      bus_rd(OFS_BUFFER_SEARCH, d);
      check(d, exp_result(16'h0801));
      check_search(16'h001F);
      $display("test restart done");
   endtask

   // ==========================================================
   // Main sequence
   initial
   begin
      ref_clk = 1'b0;
      reset = 1'b1;
      reg_addr = 11'h000;
      reg_wdata = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      failures = 0;
      cmp_count = 0;
      cycles = 0;
      for (int i = 0; i < 32; i++)
      begin
         ext_id[i] = (i % 2 == 0);
         proc_req[i] = (i % 3 == 0);
         tx_req[i] = (i % 4 < 2);
         rdy[i] = (i % 4 == 0) || (i % 4 == 3);
         new_data[i] = (i % 5 == 0);
         mask_link[i*3+:3] = 3'(i % 7);
         mod_num[i*3+:3] = 3'((i / 8) % 3);
      end
      repeat (20) @(posedge ref_clk);
      reset <= 1'b0;
      test_reset_values();
      test_counter();
      test_criteria();
      test_restart();
      end_of_test();
   end
endmodule

/* shared/cts_pkg.sv */
// Constants shared by the CAN time base and buffer search block
package cts_pkg;
   // ===========================================================
   // Register bus
   localparam int ADDR_W = 11;
   localparam int DATA_W = 16;
   localparam logic [10:0] OFS_GLOBAL_TIME_COUNTER = 11'h418;
   localparam logic [10:0] OFS_BUFFER_SEARCH = 11'h41A;
   localparam logic [15:0] RST_GLOBAL_TIME_COUNTER = 16'h0000;
   localparam logic [15:0] RST_BUFFER_SEARCH_RESULT = 16'h0000;

   // ===========================================================
   // Search start word fields
   localparam int BIT_CHECK_IDENTIFIER_TYPE = 15;
   localparam int BIT_CHECK_PROCESSING_REQUEST = 14;
   localparam int BIT_CHECK_TRANSMIT_REQUEST = 13;
   localparam int BIT_CHECK_MASK_LINK = 12;
   localparam int BIT_CHECK_NEW_DATA = 11;
   localparam int POS_SEARCH_MODULE_NUMBER = 8;
   localparam int POS_SEARCH_START_INDEX = 0;

   // ===========================================================
   // Search result word fields
   localparam int BIT_RESULT_MULTI = 9;
   localparam int BIT_RESULT_ANY = 8;
   localparam int POS_FOUND_BUFFER_INDEX = 0;

   // ===========================================================
   // Buffers and timing
   localparam int NUM_BUFFERS = 32;
   localparam logic [5:0] LAST_BUFFER = 6'h1F;
   localparam int CLK_PERIOD_NS = 100;
   localparam int TIME_TICK_NS = 1000;
   localparam int TIME_TICK_CYCLES = (TIME_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [3:0] TICK_LAST = 4'(TIME_TICK_CYCLES - 1);

   typedef enum logic [0:0]
   {
      CTS_IDLE = 1'b0,
      CTS_SCAN = 1'b1
   } cts_state_e;
endpackage

/* verilog/cts_top.sv */
// CAN global time counter and message buffer search unit
//
// Summary of operation
// - a 16-bit time counter counts up on every tick without software help.
// - any write to the time counter clears it to zero.
// - the time counter reads back its current value at any moment.
// - writing the search start word with a start index up to 31 launches a scan over the buffers.
// - bit 15 set admits only buffers holding a standard identifier.
// - bit 14 set admits only buffers with processing request set.
// - bit 12 set admits only buffers not linked to any mask.
// - bit 11 set admits only buffers with new data set.
// - bits 10 to 8 choose which module's buffers the scan considers.
// - code 000 means unassigned, 001 module 1, 010 module 2.
// - scan runs from start index to buffer 31, reporting the lowest match.
// - a read-only result at the same offset gives index and hit bits.
//
// The plain strobed port was left to the implementer.
`timescale 1ns/10ps
module cts_top
   import cts_pkg::*;
(
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [10:0] reg_addr,
   input wire logic [15:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [15:0] reg_rdata,
   input wire logic [31:0] buf_extended_id,
   input wire logic [31:0] buf_processing_request_flag,
   input wire logic [31:0] buf_transmit_request_flag,
   input wire logic [31:0] buf_ready_flag,
   input wire logic [31:0] buf_new_data_flag,
   input wire logic [95:0] buf_mask_link_select,
   input wire logic [95:0] buf_module_number,
   output logic search_busy
);

   // ===========================================================
   // State
   typedef struct packed
   {
      logic [15:0] count;
      logic [3:0] prescale;
      cts_state_e state;
      logic [5:0] idx;
      logic chk_ide;
      logic chk_erq;
      logic chk_trq;
      logic chk_msk;
      logic chk_dn;
      logic [2:0] module_sel;
      logic any;
      logic multi;
      logic [5:0] found;
      logic [15:0] result;
      logic [15:0] rdata;
   } cts_state_s;

   cts_state_s s_r;
   cts_state_s s_nxt;

   logic wr_count;
   logic wr_search;
   logic tick;
   logic hit;
   logic [4:0] bi;
   logic [2:0] buf_mask;
   logic [2:0] buf_mod;

   assign wr_count = reg_wr && (reg_addr == OFS_GLOBAL_TIME_COUNTER);
   assign wr_search = reg_wr && (reg_addr == OFS_BUFFER_SEARCH);
   assign tick = (s_r.prescale == TICK_LAST);
   assign bi = s_r.idx[4:0];
   assign buf_mask = buf_mask_link_select[bi * 3 +: 3];
   assign buf_mod = buf_module_number[bi * 3 +: 3];

   // ===========================================================
   // Match of the buffer under examination
   always_comb
   begin
      hit = 1'b1;
      if (s_r.chk_ide && buf_extended_id[bi])
      begin
         hit = 1'b0;
      end
      if (s_r.chk_erq && !buf_processing_request_flag[bi])
      begin
         hit = 1'b0;
      end
      if (s_r.chk_trq && !(buf_transmit_request_flag[bi] && buf_ready_flag[bi]))
      begin
         hit = 1'b0;
      end
      if (s_r.chk_msk && (buf_mask != 3'h0))
      begin
         hit = 1'b0;
      end
      if (s_r.chk_dn && !buf_new_data_flag[bi])
      begin
         hit = 1'b0;
      end
      if (buf_mod != s_r.module_sel)
      begin
         hit = 1'b0;
      end
   end

   // ===========================================================
   // Next state
   always_comb
   begin
      s_nxt = s_r;
      // Time base
      if (wr_count)
      begin
         s_nxt.count = 16'h0000;
         s_nxt.prescale = 4'h0;
      end
      else if (tick)
      begin
         s_nxt.count = s_r.count + 16'h0001;
         s_nxt.prescale = 4'h0;
      end
      else
      begin
         s_nxt.prescale = s_r.prescale + 4'h1;
      end

      // Search engine
      case (s_r.state)
         CTS_IDLE:
         begin
         end
         CTS_SCAN:
         begin
            if (hit)
            begin
               if (!s_r.any)
               begin
                  s_nxt.found = s_r.idx;
                  s_nxt.any = 1'b1;
               end
               else
               begin
                  s_nxt.multi = 1'b1;
               end
            end
            if (s_r.idx == LAST_BUFFER)
            begin
               s_nxt.state = CTS_IDLE;
               s_nxt.result = 16'h0000;
               s_nxt.result[BIT_RESULT_ANY] = s_r.any || hit;
               s_nxt.result[BIT_RESULT_MULTI] = s_r.multi || (s_r.any && hit);
               s_nxt.result[POS_FOUND_BUFFER_INDEX +: 6] = (!s_r.any && hit) ? s_r.idx : s_r.found;
            end
            else
            begin
               s_nxt.idx = s_r.idx + 6'h01;
            end
         end
         default:
         begin
            s_nxt.state = CTS_IDLE;
         end
      endcase

      // A new search word with start index up to 31 restarts the scan, even one in progress; a higher index stops it
      if (wr_search)
      begin
         s_nxt.chk_ide = reg_wdata[BIT_CHECK_IDENTIFIER_TYPE];
         s_nxt.chk_erq = reg_wdata[BIT_CHECK_PROCESSING_REQUEST];
         s_nxt.chk_trq = reg_wdata[BIT_CHECK_TRANSMIT_REQUEST];
         s_nxt.chk_msk = reg_wdata[BIT_CHECK_MASK_LINK];
         s_nxt.chk_dn = reg_wdata[BIT_CHECK_NEW_DATA];
         s_nxt.module_sel = reg_wdata[POS_SEARCH_MODULE_NUMBER +: 3];
         s_nxt.idx = reg_wdata[POS_SEARCH_START_INDEX +: 6];
         s_nxt.any = 1'b0;
         s_nxt.multi = 1'b0;
         s_nxt.found = 6'h00;
         if (reg_wdata[POS_SEARCH_START_INDEX +: 6] > LAST_BUFFER)
         begin
            s_nxt.state = CTS_IDLE;
            s_nxt.result = 16'h0000;
         end
         else
         begin
            s_nxt.state = CTS_SCAN;
         end
      end

      // Read data, valid the cycle after the strobe
      s_nxt.rdata = 16'h0000;
      if (reg_rd)
      begin
         if (reg_addr == OFS_GLOBAL_TIME_COUNTER)
         begin
            s_nxt.rdata = s_r.count;
         end
         else if (reg_addr == OFS_BUFFER_SEARCH)
         begin
            s_nxt.rdata = s_r.result;
         end
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (reset)
      begin
         s_r <= '0;
         s_r.count <= RST_GLOBAL_TIME_COUNTER;
         s_r.result <= RST_BUFFER_SEARCH_RESULT;
         s_r.state <= CTS_IDLE;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   assign reg_rdata = s_r.rdata;
   assign search_busy = (s_r.state == CTS_SCAN);

   // ===========================================================
   // Checks
   property p_count_inc;
      @(posedge ref_clk) disable iff (reset)
      (tick && !wr_count) |=> (s_r.count == 16'($past(s_r.count) + 16'h0001));
   endproperty
   a_count_inc: assert property (p_count_inc) else $error("time counter did not step");

   property p_count_hold;
      @(posedge ref_clk) disable iff (reset)
      (!tick && !wr_count) |=> $stable(s_r.count);
   endproperty
   a_count_hold: assert property (p_count_hold) else $error("time counter moved off tick");

   property p_count_clear;
      @(posedge ref_clk) disable iff (reset)
      wr_count |=> (s_r.count == 16'h0000) ##10 (s_r.count == 16'h0001);
   endproperty
   a_count_clear: assert property (p_count_clear) else $error("time counter not cleared");

   property p_count_read;
      @(posedge ref_clk) disable iff (reset)
      (reg_rd && reg_addr == OFS_GLOBAL_TIME_COUNTER) |=> (reg_rdata == $past(s_r.count));
   endproperty
   a_count_read: assert property (p_count_read) else $error("time counter read wrong");

   property p_start;
      @(posedge ref_clk) disable iff (reset)
      (wr_search && reg_wdata[5:0] <= LAST_BUFFER)
         |=> (search_busy && s_r.idx == $past(reg_wdata[5:0]));
   endproperty
   a_start: assert property (p_start) else $error("search did not start at index");

   property p_ide;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && s_r.chk_ide && buf_extended_id[bi]) |-> !hit;
   endproperty
   a_ide: assert property (p_ide) else $error("extended identifier matched");

   property p_erq;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && s_r.chk_erq && !buf_processing_request_flag[bi]) |-> !hit;
   endproperty
   a_erq: assert property (p_erq) else $error("processing request check ignored");

   property p_trq;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && s_r.chk_trq && !(buf_transmit_request_flag[bi] && buf_ready_flag[bi]))
         |-> !hit;
   endproperty
   a_trq: assert property (p_trq) else $error("transmit ready check ignored");

   property p_msk;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && s_r.chk_msk && buf_mask != 3'h0) |-> !hit;
   endproperty
   a_msk: assert property (p_msk) else $error("mask linked buffer matched");

   property p_dn;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && s_r.chk_dn && !buf_new_data_flag[bi]) |-> !hit;
   endproperty
   a_dn: assert property (p_dn) else $error("new data check ignored");

   property p_module;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && buf_mod != s_r.module_sel) |-> !hit;
   endproperty
   a_module: assert property (p_module) else $error("foreign module buffer matched");

   property p_open;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && !s_r.chk_ide && !s_r.chk_erq && !s_r.chk_trq && !s_r.chk_msk
         && !s_r.chk_dn && buf_mod == s_r.module_sel) |-> hit;
   endproperty
   a_open: assert property (p_open) else $error("disabled criterion excluded buffer");

   property p_end;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && s_r.idx == LAST_BUFFER && !wr_search) |=> !search_busy;
   endproperty
   a_end: assert property (p_end) else $error("scan ran past last buffer");

   property p_lowest;
      @(posedge ref_clk) disable iff (reset)
      (search_busy && hit && !s_r.any && s_r.idx == LAST_BUFFER && !wr_search)
         |=> (s_r.result[5:0] == $past(s_r.idx) && s_r.result[BIT_RESULT_ANY]);
   endproperty
   a_lowest: assert property (p_lowest) else $error("lowest match not reported");

   property p_result_read;
      @(posedge ref_clk) disable iff (reset)
      (reg_rd && reg_addr == OFS_BUFFER_SEARCH) |=> (reg_rdata == $past(s_r.result));
   endproperty
   a_result_read: assert property (p_result_read) else $error("result read wrong");

endmodule
